// ---- rtl/wdg_regs.svh ----
/*
 * Register indices, field positions, reset values and timing counts of the
 * watchdog block. Assumes APB byte addresses equal four times each index.
 */
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_CTRL_INDEX      6'h21
`define WDG_CAUSE_INDEX     6'h34
`define WDG_CTRL_RESET      8'h00
`define WDG_CAUSE_POR       4'h1
`define WDG_CAUSE_NONE      4'h0
`define WDG_RSVD_ZERO       4'h0
`define WDG_BIT_IFLAG       7
`define WDG_BIT_IEN         6
`define WDG_BIT_PSC3        5
`define WDG_BIT_CHG         4
`define WDG_BIT_EN          3
`define WDG_CAUSE_DOG       3
`define WDG_CAUSE_BROWN     2
`define WDG_CAUSE_PIN       1
`define WDG_CAUSE_PWR       0
`define WDG_CHG_CYCLES      3'h4
`define WDG_CHG_LAST        3'h1
`define WDG_CHG_IDLE        3'h0
`define WDG_BASE_SHIFT      11
`define WDG_PSC_MAX_CODE    4'h9
`define WDG_OSC_KHZ         128

`endif

// ---- rtl/wdg_pkg.sv ----
/*
 * Types shared by the watchdog files.
 * Assumes wdg_regs.svh supplies the numeric constants.
 */
package wdg_pkg;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_IRQ,
    ACT_IRQ_DISARM,
    ACT_RESET
  } wdg_action_type;

endpackage

// ---- rtl/wdg_timeout_counter.sv ----
/*
 * Timeout counter advanced by ticks of the low-frequency watchdog oscillator.
 * Assumes oscTick is a one-cycle pulse synchronous to core_clk per osc cycle.
 */
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_timeout_counter
  import wdg_pkg::*;
#(
  parameter int CNT_W = 20
)(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             restart,
  input  wire logic             run,
  input  wire logic             oscTick,
  input  wire logic [3:0]       prescaleSelect,
  output logic                  expire
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] lastCount;
  logic [3:0]       code;

  always_comb
  begin
    // Reserved codes behave as the longest period
    code      = (prescaleSelect > `WDG_PSC_MAX_CODE) ? `WDG_PSC_MAX_CODE : prescaleSelect;
    lastCount = CNT_W'((CNT_W+1)'(1) << (`WDG_BASE_SHIFT + code)) - CNT_W'(1);
    expire    = run && !restart && oscTick && (count_q == lastCount);
    if (restart || !run || expire)
    begin
      count_d = '0;
    end
    else if (oscTick)
    begin
      count_d = count_q + CNT_W'(1);
    end
    else
    begin
      count_d = count_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

endmodule

// ---- rtl/wdg_watchdog.sv ----
/*
 * Watchdog with reset-cause flags, registers reached over APB.
 * Assumes srst is the power-on reset of this block; other chip resets arrive
 * as one-cycle event pulses; oscTick marks each watchdog oscillator cycle.
 */
// Our own choice: register access over APB.
// Notes on behaviour
// - Cause register upper four bits read zero
// - Watchdog reset sets flag; zero-write clears
// - Brown-out reset sets flag; zero-write clears
// - Pin reset sets flag; zero-write clears
// - Power-on sets flag; only zero-write clears
// - Timeout in interrupt mode sets flag
// - Vector execution or one-write clears flag
// - Interrupt needs global and local enable
// - Enable pair selects stop, irq, reset
// - With enable, timeout clears interrupt enable
// - Change-enable self-clears after four cycles
// - Enable clear accepted only under change-enable
// - Prescaler changes only under change-enable
// - Level two keeps watchdog always enabled
// - Level one: dog flag forces enable
// - Prescaler codes give 2K to 1024K
// - Counter advances on watchdog oscillator ticks
// - Counter restarts on kick, disable, reset
// - Fuse picks safety level one or two
// - Reset timeout gives one-cycle reset pulse
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_watchdog
  import wdg_pkg::*;
#(
  parameter int CNT_W = 20
)(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        oscTick,
  input  wire logic        kickInstruction,
  input  wire logic        vectorTaken,
  input  wire logic        globalIntEnable,
  input  wire logic        alwaysOnFuse,
  input  wire logic        brownoutResetEvent,
  input  wire logic        pinResetEvent,
  output logic             timeoutIrq,
  output logic             systemResetPulse
);

  logic [31:0]    prdata_q;
  logic [31:0]    prdata_d;
  logic           iflag_q;
  logic           iflag_d;
  logic           ien_q;
  logic           ien_d;
  logic           chg_q;
  logic           chg_d;
  logic [2:0]     chgCnt_q;
  logic [2:0]     chgCnt_d;
  logic           en_q;
  logic           en_d;
  logic [3:0]     psc_q;
  logic [3:0]     psc_d;
  logic [3:0]     cause_q;
  logic [3:0]     cause_d;
  logic           resetPulse_q;
  logic           resetPulse_d;
  logic           enEff;
  logic           running;
  logic           expire;
  logic           chipReset;
  logic           hitCtrl;
  logic           hitCause;
  logic           wrCtrl;
  logic           wrCause;
  logic [7:0]     wbyte;
  logic [7:0]     ctrlView;
  wdg_action_type action;

  assign hitCtrl   = (paddr[7:2] == `WDG_CTRL_INDEX);
  assign hitCause  = (paddr[7:2] == `WDG_CAUSE_INDEX);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !(hitCtrl || hitCause);
  assign prdata    = prdata_q;
  assign wbyte     = pwdata[7:0];
  assign wrCtrl    = psel && penable && pwrite && hitCtrl && pstrb[0];
  assign wrCause   = psel && penable && pwrite && hitCause && pstrb[0];
  assign chipReset = resetPulse_q || brownoutResetEvent || pinResetEvent;

  // Level two: fuse holds enable; level one: dog flag holds it
  assign enEff    = alwaysOnFuse || en_q || cause_q[`WDG_CAUSE_DOG];
  assign running  = enEff || ien_q;
  assign ctrlView = {iflag_q, ien_q, psc_q[3], chg_q, enEff, psc_q[2:0]};
  assign timeoutIrq       = iflag_q && ien_q && globalIntEnable;
  assign systemResetPulse = resetPulse_q;

  wdg_timeout_counter #(
    .CNT_W          (CNT_W)
  ) u_counter (
    .core_clk       (core_clk),
    .srst           (srst),
    .restart        (kickInstruction || chipReset),
    .run            (running),
    .oscTick        (oscTick),
    .prescaleSelect (psc_q),
    .expire         (expire)
  );

  always_comb
  begin
    unique case ({ien_q, enEff})
      2'b00: action = ACT_NONE;
      2'b10: action = ACT_IRQ;
      2'b11: action = ACT_IRQ_DISARM;
      2'b01: action = ACT_RESET;
    endcase
  end

  always_comb
  begin
    iflag_d      = iflag_q;
    ien_d        = ien_q;
    chg_d        = chg_q;
    chgCnt_d     = chgCnt_q;
    en_d         = en_q;
    psc_d        = psc_q;
    cause_d      = cause_q;
    resetPulse_d = 1'b0;
    prdata_d     = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = 32'h0000_0000;
      if (hitCtrl)
      begin
        prdata_d[7:0] = ctrlView;
      end
      else if (hitCause)
      begin
        prdata_d[7:0] = {`WDG_RSVD_ZERO, cause_q};
      end
    end
    // Change window counts down four cycles
    if (chgCnt_q != `WDG_CHG_IDLE)
    begin
      chgCnt_d = chgCnt_q - 3'h1;
      if (chgCnt_q == `WDG_CHG_LAST)
      begin
        chg_d = 1'b0;
      end
    end
    if (wrCtrl)
    begin
      if (wbyte[`WDG_BIT_IFLAG])
      begin
        iflag_d = 1'b0;
      end
      ien_d = wbyte[`WDG_BIT_IEN];
      if (wbyte[`WDG_BIT_EN])
      begin
        en_d = 1'b1;
      end
      else if (chg_q)
      begin
        en_d = 1'b0;
      end
      if (chg_q)
      begin
        psc_d = {wbyte[`WDG_BIT_PSC3], wbyte[2:0]};
      end
      if (wbyte[`WDG_BIT_CHG])
      begin
        chg_d    = 1'b1;
        chgCnt_d = `WDG_CHG_CYCLES;
      end
      else
      begin
        chg_d    = 1'b0;
        chgCnt_d = `WDG_CHG_IDLE;
      end
    end
    if (vectorTaken)
    begin
      iflag_d = 1'b0;
    end
    if (wrCause)
    begin
      cause_d = cause_q & wbyte[3:0];
    end
    // Hardware events win over software clears
    if (expire)
    begin
      unique case (action)
        ACT_NONE:
        begin
        end
        ACT_IRQ:
        begin
          iflag_d = 1'b1;
        end
        ACT_IRQ_DISARM:
        begin
          iflag_d = 1'b1;
          ien_d   = 1'b0;
        end
        ACT_RESET:
        begin
          resetPulse_d                 = 1'b1;
          cause_d[`WDG_CAUSE_DOG]      = 1'b1;
        end
      endcase
    end
    if (chipReset)
    begin
      {iflag_d, ien_d, psc_d[3], chg_d, en_d, psc_d[2:0]} = `WDG_CTRL_RESET;
      chgCnt_d = `WDG_CHG_IDLE;
    end
    if (brownoutResetEvent)
    begin
      cause_d[`WDG_CAUSE_BROWN] = 1'b1;
    end
    if (pinResetEvent)
    begin
      cause_d[`WDG_CAUSE_PIN] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      {iflag_q, ien_q, psc_q[3], chg_q, en_q, psc_q[2:0]} <= `WDG_CTRL_RESET;
      chgCnt_q     <= `WDG_CHG_IDLE;
      cause_q      <= `WDG_CAUSE_POR;
      resetPulse_q <= 1'b0;
      prdata_q     <= 32'h0000_0000;
    end
    else
    begin
      iflag_q      <= iflag_d;
      ien_q        <= ien_d;
      chg_q        <= chg_d;
      chgCnt_q     <= chgCnt_d;
      en_q         <= en_d;
      psc_q        <= psc_d;
      cause_q      <= cause_d;
      resetPulse_q <= resetPulse_d;
      prdata_q     <= prdata_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_reserved_zero: assert property (
    (psel && !penable && !pwrite && hitCause) |=> (prdata[31:4] == 28'h0))
    else $error("reserved cause bits read non-zero");
  chk_dog_cause: assert property (
    (expire && action == ACT_RESET) |=> (systemResetPulse && cause_q[`WDG_CAUSE_DOG]))
    else $error("watchdog reset did not set its cause flag");
  chk_brown_cause: assert property (
    brownoutResetEvent |=> cause_q[`WDG_CAUSE_BROWN])
    else $error("brown-out cause flag not set");
  chk_pin_cause: assert property (
    pinResetEvent |=> cause_q[`WDG_CAUSE_PIN])
    else $error("pin cause flag not set");
  chk_por_cause: assert property (
    $fell(srst) |-> cause_q[`WDG_CAUSE_PWR])
    else $error("power-on cause flag not set after reset");
  chk_irq_flag: assert property (
    (expire && ien_q && !chipReset) |=> iflag_q)
    else $error("timeout flag not set in interrupt mode");
  chk_irq_gate: assert property (
    timeoutIrq |-> (globalIntEnable && ien_q && iflag_q))
    else $error("interrupt raised without both enables");
  chk_vector_clear: assert property (
    (vectorTaken && !expire) |=> !iflag_q)
    else $error("vector fetch did not clear timeout flag");
  chk_ien_disarm: assert property (
    (expire && ien_q && enEff) |=> (!ien_q && !systemResetPulse))
    else $error("interrupt enable not cleared on timeout");
  chk_chg_window: assert property (
    (wrCtrl && wbyte[`WDG_BIT_CHG] && !chipReset) ##1 (!wrCtrl && !chipReset) [*4] |=>
      (!chg_q && $past(chg_q) && $past(chg_q, 4)))
    else $error("change-enable window not four cycles");
  chk_en_guard: assert property (
    (wrCtrl && !wbyte[`WDG_BIT_EN] && !chg_q && en_q && !chipReset) |=> en_q)
    else $error("enable cleared outside change window");
  chk_psc_guard: assert property (
    (wrCtrl && !chg_q && !chipReset) |=> $stable(psc_q))
    else $error("prescaler changed outside change window");
  chk_level_two: assert property (
    (alwaysOnFuse && psel && !penable && !pwrite && hitCtrl) |=> prdata[`WDG_BIT_EN])
    else $error("watchdog disabled in level two");
  chk_pulse_once: assert property (
    systemResetPulse |=> !systemResetPulse)
    else $error("reset pulse longer than one cycle");

endmodule

// ---- testbench/wdg_core_model.sv ----
/*
 * Core-side partner: watchdog oscillator ticks and interrupt vector fetch.
 * Assumes one core_clk domain; ticks run every cycle to keep timeouts short.
 */
`timescale 1ns/1ps

module wdg_core_model (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic timeoutIrq,
  output logic      oscTick,
  output logic      vectorTaken
);
  logic [1:0] waitCnt;

  assign oscTick = ~srst;

  // Vector fetched a few cycles after the request shows
  always_ff @(posedge core_clk)
  begin
    if (srst || !timeoutIrq)
    begin
      waitCnt     <= 2'h0;
      vectorTaken <= 1'b0;
    end
    else
    begin
      waitCnt     <= waitCnt + ((waitCnt != 2'h3) ? 2'h1 : 2'h0);
      vectorTaken <= (waitCnt == 2'h2);
    end
  end
endmodule

// ---- testbench/wdg_watchdog_tb.sv ----
/*
 * Self-checking bench for wdg_watchdog with a cause-register model.
 * Assumes rtl/ on the include path and wdg_core_model beside it.
 */
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_watchdog_tb;
  localparam logic [7:0] CTRL  = 8'(`WDG_CTRL_INDEX * 4);
  localparam logic [7:0] CAUSE = 8'(`WDG_CAUSE_INDEX * 4);
  logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic        kickInstruction, globalIntEnable, alwaysOnFuse, oscTick, vectorTaken;
  logic        brownoutResetEvent, pinResetEvent, timeoutIrq, systemResetPulse;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd, lfsrState;
  int          num_errors, compares, expCause, n;

  wdg_watchdog #(.CNT_W(20)) wdg_watchdog_inst (.core_clk(core_clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscTick(oscTick), .kickInstruction(kickInstruction), .vectorTaken(vectorTaken),
    .globalIntEnable(globalIntEnable), .alwaysOnFuse(alwaysOnFuse),
    .brownoutResetEvent(brownoutResetEvent), .pinResetEvent(pinResetEvent),
    .timeoutIrq(timeoutIrq), .systemResetPulse(systemResetPulse));
  wdg_core_model wdg_core_model_inst (.core_clk(core_clk), .srst(srst),
    .timeoutIrq(timeoutIrq), .oscTick(oscTick), .vectorTaken(vectorTaken));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test();
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // Kind 0 kick, 1 brown-out, 2 pin reset
  task automatic ev(input int k);
    @(posedge core_clk);
    {pinResetEvent, brownoutResetEvent, kickInstruction} <= 3'(1 << k);
    @(posedge core_clk);
    {pinResetEvent, brownoutResetEvent, kickInstruction} <= 3'h0;
  endtask

  task automatic waitFor(input int sel, output int c);
    c = 0;
    while ((sel == 0 ? timeoutIrq : systemResetPulse) !== 1'b1 && c < 5000)
    begin
      @(posedge core_clk);
      c++;
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, kickInstruction, globalIntEnable} = 5'h0;
    {alwaysOnFuse, brownoutResetEvent, pinResetEvent} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    srst = 1'b1;
    lfsrState = 32'hb4d4;
    expCause = 1;
    num_errors = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rdchk(CAUSE, 8'h01);
    rdchk(CTRL, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk({31'h0, err}, 32'h1);
    repeat (4)
    begin
      lfsrState = lfsr(lfsrState);
      apb(1'b1, CAUSE, lfsrState[7:0]);
      expCause = expCause & int'(lfsrState[3:0]);
      rdchk(CAUSE, 8'(expCause));
    end
    ev(1);
    expCause |= 4;
    rdchk(CAUSE, 8'(expCause));
    ev(2);
    expCause |= 2;
    rdchk(CAUSE, 8'(expCause));
    pstrb <= 4'he;
    apb(1'b1, CAUSE, 8'h00);
    pstrb <= 4'hf;
    rdchk(CAUSE, 8'(expCause));
    apb(1'b1, CAUSE, 8'h00);
    rdchk(CAUSE, 8'h00);
    apb(1'b1, CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h0a);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h09);
    rdchk(CTRL, 8'h09);
    apb(1'b1, CTRL, 8'h19);
    rdchk(CTRL, 8'h19);
    repeat (6) @(posedge core_clk);
    rdchk(CTRL, 8'h09);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h09);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h00);
    repeat (2100) @(posedge core_clk);
    rdchk(CAUSE, 8'h00);
    rdchk(CTRL, 8'h00);
    globalIntEnable <= 1'b1;
    apb(1'b1, CTRL, 8'h40);
    repeat (3)
    begin
      repeat (1500) @(posedge core_clk);
      ev(0);
    end
    waitFor(0, n);
    chk(32'(n > 2040 && n < 2060), 32'h1);
    repeat (5) @(posedge core_clk);
    chk({31'h0, timeoutIrq}, 32'h0);
    rdchk(CTRL, 8'h40);
    waitFor(0, n);
    chk(32'(n > 2020 && n < 2050), 32'h1);
    globalIntEnable <= 1'b0;
    rdchk(CTRL, 8'hc0);
    chk({31'h0, timeoutIrq}, 32'h0);
    apb(1'b1, CTRL, 8'hc0);
    rdchk(CTRL, 8'h40);
    apb(1'b1, CTRL, 8'h48);
    ev(0);
    repeat (2100) @(posedge core_clk);
    rdchk(CTRL, 8'h88);
    waitFor(1, n);
    chk(32'(n > 1900 && n < 2000), 32'h1);
    @(posedge core_clk);
    chk({31'h0, systemResetPulse}, 32'h0);
    rdchk(CAUSE, 8'h08);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CAUSE, 8'h00);
    rdchk(CTRL, 8'h00);
    alwaysOnFuse <= 1'b1;
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    stop_test();
  end
endmodule
